// ### rtl/flash_cmd_pkg.sv
// Constants, encodings and carrier types for the flash command sequencer
// Notes on behaviour
// [R1] Resume is chip select low, resume code shifted in, ended by chip select high.
// [R2] During program suspend, reads outside the suspended page are served; inside are undefined.
// [R3] During erase suspend, reads and programs outside the suspended sector are served.
// [R4] Program into erase-suspended sector dropped; program-fail flag set, write latch kept.
// [R5] Erase resume does not recheck volatile lock bits changed while suspended.
// [R6] Accepted resume sets write-in-progress and clears the controller-ready flag.
// [R7] Resume with nothing suspended is ignored.
// [R8] Resumed operation completion returns the controller-ready flag to one.
// [R9] OTP read: command, address, dummy clocks in; data out on falling clock edges.
// [R10] OTP read address increments per byte, sticking at 0x40 until chip select rises.
// [R11] OTP program ignored without write enable latch, and no flags set.
// [R12] Chip select rising after whole bytes launches self-timed OTP programming.
// [R13] At most 65 program data bytes latched, extra bytes discarded, no wrap.
// [R14] OTP program writes at most 64 data bytes plus the control byte.
// [R15] Write-in-progress high while programming; write latch cleared afterwards regardless.
// [R16] OTP programming timeout clears write latch and sets program-fail flag.
// [R17] Badly ended OTP program not executed, no flags, write latch stays set.
// [R18] Host waits for controller-ready flag one after a full status byte.
// [R19] Control byte bit 0 locks OTP when zero; never returns to one.
// [R20] Program to locked OTP ignored; write latch kept, flag bits 1 and 4 set.
// [R21] B7h enters four-byte addressing, E9h returns to three-byte, immediately.
// [R22] 35h enters quad mode, F5h leaves it, immediately, without write enable.
// [R23] Program suspend sets flag bit 2, erase suspend sets flag bit 6.
// [R24] Accepted resume clears the suspend flag of the operation resumed.
package flash_cmd_pkg;

    localparam logic [7:0] CMD_RESUME     = 8'h7a;
    localparam logic [7:0] CMD_READ_OTP   = 8'h4b;
    localparam logic [7:0] CMD_PROG_OTP   = 8'h42;
    localparam logic [7:0] CMD_WREN       = 8'h06;
    localparam logic [7:0] CMD_WRDI       = 8'h04;
    localparam logic [7:0] CMD_CLR_FLAGS  = 8'h50;
    localparam logic [7:0] CMD_ADDR4_ON   = 8'hb7;
    localparam logic [7:0] CMD_ADDR4_OFF  = 8'he9;
    localparam logic [7:0] CMD_QUAD_ON    = 8'h35;
    localparam logic [7:0] CMD_QUAD_OFF   = 8'hf5;

    localparam int         OTP_BYTES      = 65;
    localparam logic [6:0] OTP_CTRL_IDX   = 7'h40;
    localparam logic [6:0] OTP_MAX_LATCH  = 7'h41;
    localparam int         OTP_LOCK_BIT   = 0;
    localparam logic [7:0] OTP_ERASED     = 8'hff;
    localparam int         PAGE_LSB       = 8;
    localparam int         SECTOR_LSB     = 16;

    localparam int         CLK_PERIOD_PS  = 4000;
    localparam int         OTP_PROG_US    = 2000;
    localparam int         OTP_PROG_CYC   = (OTP_PROG_US * 1000000) / CLK_PERIOD_PS;

    typedef struct packed {
        logic ctrl_ready;
        logic erase_susp;
        logic rsvd5;
        logic prog_fail;
        logic rsvd3;
        logic prog_susp;
        logic prot_err;
        logic rsvd0;
    } flag_status_t;

    localparam flag_status_t FSR_RESET = 8'h80;

    typedef struct packed {
        logic wel;
        logic wip;
    } status_t;

    typedef struct packed {
        logic        valid;
        logic        is_prog;
        logic [31:0] addr;
    } mem_req_t;

    typedef enum logic [4:0] {
        ST_CMD   = 5'b00001,
        ST_ADDR  = 5'b00010,
        ST_DUMMY = 5'b00100,
        ST_RDATA = 5'b01000,
        ST_PDATA = 5'b10000
    } frame_state_t;

endpackage

// ### rtl/flash_cmd_seq.sv
// Serial command front end: resume, OTP read/program, address and quad modes
module flash_cmd_seq #(
    parameter int OTP_PROG_CYCLES = flash_cmd_pkg::OTP_PROG_CYC
) (
    input  wire logic                    sys_clk_in,
    input  wire logic                    rst_in,
    input  wire logic                    chip_sel_n_in,
    input  wire logic                    serial_clk_in,
    input  wire logic                    serial_in_line_in,
    output logic                         serial_out_line_out,
    output logic                         serial_out_line_oe_out,
    input  wire logic                    prog_suspend_in,
    input  wire logic                    erase_suspend_in,
    input  wire logic [31:0]             suspend_addr_in,
    input  wire logic                    array_op_done_in,
    input  wire logic                    otp_timeout_in,
    input  wire flash_cmd_pkg::mem_req_t mem_req_in,
    output logic                         mem_read_undefined_out,
    output logic                         mem_prog_reject_out,
    output logic                         resume_prog_out,
    output logic                         resume_erase_out,
    output flash_cmd_pkg::status_t       status_out,
    output flash_cmd_pkg::flag_status_t  flag_status_out,
    output logic                         addr4_mode_out,
    output logic                         quad_mode_out
);
    import flash_cmd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    logic [2:0] cs_sync_q;
    logic [2:0] sclk_sync_q;
    logic [1:0] din_sync_q;

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            cs_sync_q   <= 3'h7;
            sclk_sync_q <= 3'h0;
            din_sync_q  <= 2'h0;
        end
        else
        begin
            cs_sync_q   <= {cs_sync_q[1:0], chip_sel_n_in};
            sclk_sync_q <= {sclk_sync_q[1:0], serial_clk_in};
            din_sync_q  <= {din_sync_q[0], serial_in_line_in};
        end
    end

    logic cs_active;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic din;

    // Edges come from stages two and three; stage one feeds only stage two
    assign cs_active = ~cs_sync_q[1];
    assign cs_rise   = cs_sync_q[1] & ~cs_sync_q[2];
    assign sclk_rise = cs_active & sclk_sync_q[1] & ~sclk_sync_q[2];
    assign sclk_fall = cs_active & ~sclk_sync_q[1] & sclk_sync_q[2];
    assign din       = din_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Frame decoder
    frame_state_t state_q;
    logic [7:0]   shift_q;
    logic [2:0]   bit_q;
    logic [6:0]   bytes_q;
    logic [7:0]   cmd_q;
    logic [31:0]  addr_q;
    logic [7:0]   byte_d;
    logic [31:0]  addr_d;
    logic         byte_done;
    logic         cmd_done;
    logic [6:0]   addr_bytes;
    logic         addr4_q;
    logic         quad_q;
    logic         wel_q;
    logic         wip_q;
    logic         otp_busy_q;
    logic         resume_ok;

    assign byte_d     = {shift_q[6:0], din};
    assign addr_d     = {addr_q[23:0], byte_d};
    assign byte_done  = sclk_rise && (bit_q == 3'h7);
    assign cmd_done   = byte_done && (state_q == ST_CMD);
    assign addr_bytes = addr4_q ? 7'h4 : 7'h3;

    function automatic logic [6:0] otp_index(input logic [31:0] a);
        otp_index = (a > 32'(OTP_CTRL_IDX)) ? OTP_CTRL_IDX : a[6:0];
    endfunction

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in || !cs_active)
        begin
            state_q <= ST_CMD;
            shift_q <= 8'h00;
            bit_q   <= 3'h0;
            bytes_q <= 7'h00;
            cmd_q   <= 8'h00;
            addr_q  <= 32'h0000_0000;
        end
        else if (sclk_rise)
        begin
            shift_q <= byte_d;
            bit_q   <= bit_q + 3'h1;
            if (bit_q == 3'h7)
            begin
                if (bytes_q != 7'h7f)
                    bytes_q <= bytes_q + 7'h1;
                case (state_q)
                    ST_CMD:
                    begin
                        cmd_q <= byte_d;
                        if (!otp_busy_q && byte_d == CMD_READ_OTP)
                        begin
                            state_q <= ST_ADDR;                               // [R9]
                        end
                        else if (!otp_busy_q && byte_d == CMD_PROG_OTP && wel_q)
                        begin
                            state_q <= ST_ADDR;                               // [R11]
                        end
                        else
                        begin
                            // Unknown or refused codes park in command state
                            state_q <= ST_CMD;
                        end
                    end
                    ST_ADDR:
                    begin
                        addr_q <= addr_d;
                        if (bytes_q == addr_bytes)
                        begin
                            state_q <= (cmd_q == CMD_READ_OTP) ? ST_DUMMY : ST_PDATA;
                        end
                    end
                    // Eight dummy clocks are exactly one byte time
                    ST_DUMMY: state_q <= ST_RDATA;                            // [R9]
                    default:  state_q <= state_q;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Immediate mode commands
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            addr4_q <= 1'b0;
            quad_q  <= 1'b0;
        end
        else if (cmd_done && !otp_busy_q)
        begin
            if (byte_d == CMD_ADDR4_ON)
                addr4_q <= 1'b1;                                              // [R21]
            else if (byte_d == CMD_ADDR4_OFF)
                addr4_q <= 1'b0;                                              // [R21]
            else if (byte_d == CMD_QUAD_ON)
                quad_q <= 1'b1;                                               // [R22]
            else if (byte_d == CMD_QUAD_OFF)
                quad_q <= 1'b0;                                               // [R22]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // OTP storage, program buffer and read pointer
    logic [7:0] otp_mem_q [OTP_BYTES];
    logic [7:0] pbuf_q    [OTP_BYTES];
    logic [6:0] pidx_q;
    logic [6:0] pcnt_q;
    logic [6:0] ridx_q;
    logic [2:0] rbit_q;
    logic       otp_locked;
    logic       otp_end_ok;
    logic       otp_start;
    logic       otp_finish;
    logic       otp_addr_skip_q;
    logic [31:0] otp_timer_q;

    assign otp_locked = ~otp_mem_q[OTP_CTRL_IDX][OTP_LOCK_BIT];               // [R19]
    // Whole bytes only and at least one data byte, else nothing happens
    assign otp_end_ok = cs_rise && (state_q == ST_PDATA) && (bit_q == 3'h0)
                        && (pcnt_q != 7'h00) && wel_q;                        // [R12] [R17]
    assign otp_start  = otp_end_ok && !otp_locked;
    assign otp_finish = otp_busy_q && (otp_timer_q == 32'h0);

    always_ff @(posedge sys_clk_in)
    begin
        // Busy keeps the buffer: a refused program must not spoil the running one
        if (rst_in || (cmd_done && byte_d == CMD_PROG_OTP && !otp_busy_q))
        begin
            for (int i = 0; i < OTP_BYTES; i++)
                pbuf_q[i] <= OTP_ERASED;
            pidx_q          <= 7'h00;
            pcnt_q          <= 7'h00;
            otp_addr_skip_q <= 1'b0;
        end
        else if (byte_done && state_q == ST_ADDR && bytes_q == addr_bytes)
        begin
            pidx_q          <= otp_index(addr_d);
            otp_addr_skip_q <= (addr_d > 32'(OTP_CTRL_IDX));
        end
        else if (byte_done && state_q == ST_PDATA && pcnt_q < OTP_MAX_LATCH)
        begin
            // No wrap: the index stops past the control byte
            if (!otp_addr_skip_q)
            begin
                pbuf_q[pidx_q] <= byte_d;                                     // [R13]
                otp_addr_skip_q <= (pidx_q == OTP_CTRL_IDX);
                pidx_q <= pidx_q + 7'h1;
            end
            pcnt_q <= pcnt_q + 7'h1;                                          // [R13]
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < OTP_BYTES; i++)
                otp_mem_q[i] <= OTP_ERASED;
        end
        else if (otp_finish && !otp_timeout_in)
        begin
            // Bits only go from one to zero, so a lock can never be undone
            for (int i = 0; i < OTP_BYTES; i++)
                otp_mem_q[i] <= otp_mem_q[i] & pbuf_q[i];                     // [R14] [R19]
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            otp_busy_q  <= 1'b0;
            otp_timer_q <= 32'h0;
        end
        else if (otp_start)
        begin
            otp_busy_q  <= 1'b1;                                              // [R12]
            otp_timer_q <= 32'(OTP_PROG_CYCLES - 1);
        end
        else if (otp_finish)
            otp_busy_q <= 1'b0;
        else if (otp_busy_q)
            otp_timer_q <= otp_timer_q - 32'h1;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in || !cs_active)
        begin
            ridx_q              <= 7'h00;
            rbit_q              <= 3'h7;
            serial_out_line_out <= 1'b0;
        end
        else if (byte_done && state_q == ST_ADDR && bytes_q == addr_bytes)
            ridx_q <= otp_index(addr_d);
        else if (sclk_fall && state_q == ST_RDATA)
        begin
            serial_out_line_out <= otp_mem_q[ridx_q][rbit_q];                 // [R9]
            rbit_q              <= rbit_q - 3'h1;
            if (rbit_q == 3'h0 && ridx_q != OTP_CTRL_IDX)
                ridx_q <= ridx_q + 7'h1;                                      // [R10]
        end
    end

    // Driven only in the data phase; quad mode still reads on one line here
    assign serial_out_line_oe_out = cs_active && (state_q == ST_RDATA);

    ////////////////////////////////////////////////////////////////////////
    // Suspend bookkeeping and resume
    logic [31:0] prog_susp_addr_q;
    logic [31:0] erase_susp_addr_q;
    flag_status_t fsr_q;
    logic        resume_prog;
    logic        resume_erase;
    logic        prog_reject;
    logic        wel_d;

    assign resume_ok    = cs_rise && (cmd_q == CMD_RESUME) && (bytes_q == 7'h1)
                          && (bit_q == 3'h0);                                 // [R1]
    // Nested suspend: the later program resumes before the erase
    assign resume_prog  = resume_ok && fsr_q.prog_susp;                       // [R7]
    assign resume_erase = resume_ok && !fsr_q.prog_susp && fsr_q.erase_susp;  // [R7]
    assign prog_reject  = mem_req_in.valid && mem_req_in.is_prog && fsr_q.erase_susp
                          && (mem_req_in.addr[31:SECTOR_LSB]
                              == erase_susp_addr_q[31:SECTOR_LSB]);           // [R3] [R4]

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            prog_susp_addr_q  <= 32'h0000_0000;
            erase_susp_addr_q <= 32'h0000_0000;
        end
        else
        begin
            if (prog_suspend_in)
                prog_susp_addr_q <= suspend_addr_in;
            if (erase_suspend_in)
                erase_susp_addr_q <= suspend_addr_in;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            mem_read_undefined_out <= 1'b0;
            mem_prog_reject_out    <= 1'b0;
            resume_prog_out        <= 1'b0;
            resume_erase_out       <= 1'b0;
        end
        else
        begin
            mem_read_undefined_out <= mem_req_in.valid && !mem_req_in.is_prog
                && ((fsr_q.prog_susp && mem_req_in.addr[31:PAGE_LSB]
                     == prog_susp_addr_q[31:PAGE_LSB])                        // [R2]
                 || (fsr_q.erase_susp && mem_req_in.addr[31:SECTOR_LSB]
                     == erase_susp_addr_q[31:SECTOR_LSB]));                   // [R3]
            mem_prog_reject_out    <= prog_reject;                            // [R4]
            resume_prog_out        <= resume_prog;
            // No lock recheck: the erase simply carries on
            resume_erase_out       <= resume_erase;                           // [R5]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status, write latch and flag status
    always_comb
    begin
        wel_d = wel_q;
        if (cmd_done && byte_d == CMD_WREN)
            wel_d = 1'b1;
        else if (cmd_done && byte_d == CMD_WRDI)
            wel_d = 1'b0;
        if (otp_finish)
            wel_d = 1'b0;                                                     // [R15] [R16]
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            wel_q <= 1'b0;
            wip_q <= 1'b0;
        end
        else
        begin
            wel_q <= wel_d;
            if (otp_start || resume_prog || resume_erase)
                wip_q <= 1'b1;                                                // [R6] [R15]
            else if (otp_finish || array_op_done_in || prog_suspend_in || erase_suspend_in)
                wip_q <= 1'b0;                                                // [R15]
        end
    end

    // Sets are applied after clears so a coincident event is kept
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            fsr_q <= FSR_RESET;
        end
        else
        begin
            if (cmd_done && byte_d == CMD_CLR_FLAGS)
            begin
                fsr_q.prog_fail <= 1'b0;
                fsr_q.prot_err  <= 1'b0;
            end
            if (resume_prog)
                fsr_q.prog_susp <= 1'b0;                                      // [R24]
            if (resume_erase)
                fsr_q.erase_susp <= 1'b0;                                     // [R24]
            if (otp_start || resume_prog || resume_erase)
                fsr_q.ctrl_ready <= 1'b0;                                     // [R6]
            if (otp_finish || array_op_done_in || prog_suspend_in || erase_suspend_in)
                fsr_q.ctrl_ready <= 1'b1;                                     // [R8] [R18]
            if (prog_suspend_in)
                fsr_q.prog_susp <= 1'b1;                                      // [R23]
            if (erase_suspend_in)
                fsr_q.erase_susp <= 1'b1;                                     // [R23]
            if (prog_reject || (otp_finish && otp_timeout_in))
                fsr_q.prog_fail <= 1'b1;                                      // [R4] [R16]
            if (otp_end_ok && otp_locked)
            begin
                fsr_q.prog_fail <= 1'b1;                                      // [R20]
                fsr_q.prot_err  <= 1'b1;                                      // [R20]
            end
        end
    end

    assign status_out      = '{wel: wel_q, wip: wip_q};
    assign flag_status_out = fsr_q;
    assign addr4_mode_out  = addr4_q;
    assign quad_mode_out   = quad_q;

endmodule

// ### verification/flash_cmd_props_properties.sv
// Port-level assertions for the flash command sequencer
module flash_cmd_props (
    input wire logic                        sys_clk_in,
    input wire logic                        rst_in,
    input wire logic                        chip_sel_n_in,
    input wire logic                        array_op_done_in,
    input wire flash_cmd_pkg::mem_req_t     mem_req_in,
    input wire logic                        serial_out_line_oe_out,
    input wire logic                        mem_prog_reject_out,
    input wire logic                        resume_prog_out,
    input wire logic                        resume_erase_out,
    input wire flash_cmd_pkg::status_t      status_out,
    input wire flash_cmd_pkg::flag_status_t flag_status_out,
    input wire logic                        addr4_mode_out,
    input wire logic                        quad_mode_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    resume_sets_busy_a: assert property ((resume_prog_out || resume_erase_out) |->
        ##[0:1] (status_out.wip && !flag_status_out.ctrl_ready)) else $error("resume not busy");
    resume_needs_susp_a: assert property (resume_prog_out |->
        ($past(flag_status_out.prog_susp) || flag_status_out.prog_susp)) else $error("bad resume");
    erase_susp_clear_a: assert property (resume_erase_out |->
        ##[0:1] !flag_status_out.erase_susp) else $error("erase suspend kept");
    reject_cause_a: assert property (mem_prog_reject_out |->
        $past(mem_req_in.valid && mem_req_in.is_prog && flag_status_out.erase_susp))
        else $error("reject without cause");
    reject_flag_a: assert property (mem_prog_reject_out |-> ##[0:1] flag_status_out.prog_fail)
        else $error("reject without fail flag");
    done_ready_a: assert property (array_op_done_in |-> ##[1:2]
        (flag_status_out.ctrl_ready && !status_out.wip)) else $error("done not ready");
    idle_ready_a: assert property ($fell(status_out.wip) |-> flag_status_out.ctrl_ready)
        else $error("idle but not ready");
    locked_flags_a: assert property ($rose(flag_status_out.prot_err) |->
        flag_status_out.prog_fail && status_out.wel) else $error("lock flags wrong");
    deselect_quiet_a: assert property (chip_sel_n_in [*6] |-> !serial_out_line_oe_out)
        else $error("drives while deselected");
    mode_in_frame_a: assert property (($changed(addr4_mode_out) || $changed(quad_mode_out))
        |-> !$past(chip_sel_n_in, 4)) else $error("mode change outside frame");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind flash_cmd_seq flash_cmd_props props (.sys_clk_in,
    .rst_in, .chip_sel_n_in, .array_op_done_in, .mem_req_in, .serial_out_line_oe_out,
    .mem_prog_reject_out, .resume_prog_out, .resume_erase_out, .status_out, .flag_status_out,
    .addr4_mode_out, .quad_mode_out);

// ### verification/flash_host_model.sv
// Serial host model driving select, clock and data into the device
module flash_host_model (
    input  wire logic clk_in,
    input  wire logic dout_in,
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      din_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        din_out = 1'b0;
    end
    // Half of the 160 ns serial period; clock stands low between frames
    task automatic hold();
        repeat (20) @(negedge clk_in);
    endtask
    task automatic open_frame();
        hold();
        cs_n_out = 1'b0;
        hold();
    endtask
    task automatic close_frame();
        hold();
        cs_n_out = 1'b1;
        din_out = ~din_out;
        hold();
    endtask
    task automatic shift(input logic [7:0] b, input int n, output logic [7:0] r);
        for (int i = 0; i < n; i++)
        begin
            din_out = b[7 - i];
            hold();
            sclk_out = 1'b1;
            r = {r[6:0], dout_in};
            hold();
            sclk_out = 1'b0;
        end
    endtask
endmodule

// ### verification/test_serial_flash_resume_otp_mode_cmds.sv
// Self-checking bench for resume, OTP and mode commands
module test_serial_flash_resume_otp_mode_cmds;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_cmd_pkg::*;
    logic         sys_clk_in = 1'b0, rst_in = 1'b1, ps = 1'b0, es = 1'b0, done = 1'b0;
    logic         tmo = 1'b0, cs_n, sclk, din, dout, oe, und, rej, a4, qd;
    logic [31:0]  sa = 32'h0;
    logic [7:0]   r, mc[4], me[4];
    logic [23:0]  q;
    mem_req_t     mr = '0;
    status_t      st;
    flag_status_t fs;
    int           miscompares = 0, n_tests = 0, cyc = 0;
    wire [7:0]    sw = {6'h0, st};
    wire [7:0]    md = {6'h0, a4, qd};
    flash_host_model h (.clk_in(sys_clk_in), .dout_in(dout), .cs_n_out(cs_n),
        .sclk_out(sclk), .din_out(din));
    flash_cmd_seq #(.OTP_PROG_CYCLES(60)) dut (.sys_clk_in, .rst_in, .chip_sel_n_in(cs_n),
        .serial_clk_in(sclk), .serial_in_line_in(din), .serial_out_line_out(dout),
        .serial_out_line_oe_out(oe), .prog_suspend_in(ps), .erase_suspend_in(es),
        .suspend_addr_in(sa), .array_op_done_in(done), .otp_timeout_in(tmo), .mem_req_in(mr),
        .mem_read_undefined_out(und), .mem_prog_reject_out(rej), .resume_prog_out(),
        .resume_erase_out(), .status_out(st), .flag_status_out(fs), .addr4_mode_out(a4),
        .quad_mode_out(qd));
    initial forever #2 sys_clk_in = ~sys_clk_in;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge sys_clk_in)
    begin
        cyc++;
        if (cyc == 100000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic cmd(input logic [7:0] c);
        h.open_frame(); h.shift(c, 8, r); h.close_frame();
    endtask
    task automatic hdr(input logic [7:0] c, input logic [7:0] a);
        h.open_frame(); h.shift(c, 8, r); h.shift(8'h00, 8, r); h.shift(8'h00, 8, r);
        h.shift(a, 8, r);
    endtask
    // Bit count that is not 8 or 16 leaves a ragged final byte on purpose
    task automatic otp_pg(input logic [7:0] a, input logic [15:0] d, input int nb);
        hdr(CMD_PROG_OTP, a); h.shift(d[15:8], nb > 8 ? 8 : nb, r);
        if (nb > 8) h.shift(d[7:0], nb - 8, r);
        h.close_frame();
    endtask
    task automatic otp_rd(input logic [7:0] a);
        hdr(CMD_READ_OTP, a); h.shift(8'h00, 8, r);
        repeat (3) begin h.shift(8'h00, 8, r); q = {q[15:0], r}; end
        h.close_frame();
    endtask
    task automatic idle();
        for (int i = 0; i < 200 && fs.ctrl_ready !== 1'b1; i++) @(negedge sys_clk_in);
    endtask
    task automatic pulse_done();
        @(negedge sys_clk_in) done = 1'b1; @(negedge sys_clk_in) done = 1'b0;
        repeat (2) @(negedge sys_clk_in);
    endtask
    task automatic susp(input logic e, input logic [31:0] a);
        @(negedge sys_clk_in) begin sa = a; es = e; ps = ~e; end
        @(negedge sys_clk_in) begin es = 1'b0; ps = 1'b0; end
        repeat (2) @(negedge sys_clk_in);
    endtask
    task automatic mreq(input logic p, input logic [31:0] a, input logic [1:0] e);
        @(negedge sys_clk_in) mr = '{1'b1, p, a};
        @(negedge sys_clk_in) chk({6'h0, und, rej}, {6'h0, e});
        mr = '0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mc = '{CMD_ADDR4_ON, CMD_QUAD_ON, CMD_ADDR4_OFF, CMD_QUAD_OFF};
        me = '{8'h02, 8'h03, 8'h01, 8'h00};
        repeat (6) @(negedge sys_clk_in);
        rst_in = 1'b0;
        repeat (3) @(negedge sys_clk_in);
        chk(fs, 8'h80);
        chk(sw, 8'h00);
        for (int i = 0; i < 4; i++) begin cmd(mc[i]); chk(md, me[i]); end
        cmd(CMD_RESUME); chk(sw, 8'h00); chk(fs, 8'h80);
        susp(1'b0, 32'h0001_2300); chk(fs, 8'h84);
        mreq(1'b0, 32'h0001_23ff, 2'b10); mreq(1'b0, 32'h0001_2400, 2'b00);
        cmd(CMD_RESUME); chk(sw, 8'h01); chk(fs, 8'h00);
        pulse_done(); chk(fs, 8'h80);
        cmd(CMD_WREN); susp(1'b1, 32'h0005_0000); chk(fs, 8'hc0);
        mreq(1'b1, 32'h0005_ff00, 2'b01); mreq(1'b0, 32'h0005_0010, 2'b10);
        mreq(1'b1, 32'h0006_0000, 2'b00); chk(fs, 8'hd0); chk(sw, 8'h02);
        cmd(CMD_RESUME); chk(fs, 8'h10); pulse_done(); chk(fs, 8'h90);
        cmd(CMD_CLR_FLAGS); chk(fs, 8'h80);
        otp_pg(8'h00, 16'h0000, 4); chk(sw, 8'h02); chk(fs, 8'h80);
        otp_pg(8'h3f, 16'h1235, 16); chk(sw & 8'h01, 8'h01);
        idle(); chk(sw, 8'h00); chk(fs, 8'h80);
        otp_pg(8'h00, 16'h0000, 8); chk(sw, 8'h00); chk(fs, 8'h80);
        cmd(CMD_WREN); tmo = 1'b1; otp_pg(8'h00, 16'h0000, 8); idle();
        tmo = 1'b0; chk(sw, 8'h00); chk(fs, 8'h90); cmd(CMD_CLR_FLAGS);
        otp_rd(8'h3f); chk(q[23:16], 8'h12); chk(q[15:8], 8'h35); chk(q[7:0], 8'h35);
        otp_rd(8'h00); chk(q[23:16], 8'hff);
        cmd(CMD_WREN); otp_pg(8'h40, 16'h3400, 8); idle(); cmd(CMD_WREN);
        otp_pg(8'h00, 16'h0000, 8); chk(sw, 8'h02); chk(fs, 8'h92);
        wrap_up();
    end
endmodule
